// ### hdl/ctc_trigger_ctrl.v
// trigger and acquisition control with wishbone registers and frame word stream
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`include "ctc_map.vh"

// How it works
// R1 - entering trigger mode puts the block straight into waiting for a trigger, with no arm step.
// R2 - an accepted trigger starts an exposure and frame data follows only after the exposure ends.
// R3 - the trigger source is chosen among software, the isolated input and the two non-isolated lines.
// R4 - outside counter mode, a software trigger command from the host makes the block acquire and send an image.
// R5 - single and cyclic software operations work only while software is the chosen source.
// R6 - outside equipment drives a high pulse on the chosen line to trigger.
// R7 - in single-frame mode each accepted trigger gives one exposure and one frame.
// R8 - in burst mode one trigger gives a programmable count of 1 to 65535 frames.
// R9 - in counter mode one acquisition starts for every N triggers, N from 1 to 1023.
// R10 - the line feeding the divider is selected on its own.
// R11 - a counter-reset command clears the divider count back to zero.
// R12 - each non-isolated line is set as input or output on its own.
// R13 - triggers during an exposure or burst are ignored until the last frame is out.
module ctc_trigger_ctrl #(
    parameter DATA_W = 32
) (
    input  wire              clk_i,
    input  wire              rst_i,
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    input  wire              wb_we_i,
    input  wire [7:0]        wb_adr_i,
    input  wire [3:0]        wb_sel_i,
    input  wire [31:0]       wb_dat_i,
    output reg  [31:0]       wb_dat_o,
    output reg               wb_ack_o,
    input  wire              isolated_in_i,
    input  wire              nonisolated_line_a_i,
    output wire              nonisolated_line_a_o,
    output wire              nonisolated_line_a_oe_o,
    input  wire              nonisolated_line_b_i,
    output wire              nonisolated_line_b_o,
    output wire              nonisolated_line_b_oe_o,
    output reg               exposing_o,
    output wire [DATA_W-1:0] frame_data_o,
    output wire              frame_valid_o,
    input  wire              frame_ready_i,
    output reg               frame_last_o
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_WAIT = 4'h2;
    localparam [3:0] ST_EXPO = 4'h4;
    localparam [3:0] ST_SEND = 4'h8;

    reg  [11:0] ctrl;
    reg  [15:0] burst_cnt;
    reg  [9:0]  div_ratio;
    reg  [15:0] expose_len;
    reg  [3:0]  state;
    reg  [15:0] timer;
    reg  [15:0] frames_left;
    reg  [15:0] word_idx;
    reg  [9:0]  div_cnt;
    reg  [2:0]  line_q;
    reg  [15:0] frame_cnt;
    reg         soft_req;
    reg         cnt_clr;
    reg         stop_req;
    reg         last_flag;
    wire [1:0]  src;
    wire [1:0]  acq;
    wire [1:0]  csrc;
    wire [2:0]  line_now;
    wire [2:0]  line_rise;
    reg         src_pulse;
    reg         cnt_pulse;
    reg         trig;
    wire        wb_req;
    wire        wr;
    wire        push;
    wire        push_ready;
    wire [DATA_W-1:0] push_data;
    wire        last_word;
    wire [DATA_W:0] skid_out;

    assign src    = ctrl[`CTC_CTRL_SRC_HI:`CTC_CTRL_SRC_LO];
    assign acq    = ctrl[`CTC_CTRL_ACQ_HI:`CTC_CTRL_ACQ_LO];
    assign csrc   = ctrl[`CTC_CTRL_CSRC_HI:`CTC_CTRL_CSRC_LO];
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr     = wb_req & wb_we_i;

    // R12 per-line direction
    assign nonisolated_line_a_oe_o = ctrl[`CTC_CTRL_DIR_A];
    assign nonisolated_line_b_oe_o = ctrl[`CTC_CTRL_DIR_B];
    assign nonisolated_line_a_o    = ctrl[`CTC_CTRL_OUT_A];
    assign nonisolated_line_b_o    = ctrl[`CTC_CTRL_OUT_B];

    // a line driven as output is masked so the block cannot trigger itself
    assign line_now  = {nonisolated_line_b_i & ~ctrl[`CTC_CTRL_DIR_B],
                        nonisolated_line_a_i & ~ctrl[`CTC_CTRL_DIR_A],
                        isolated_in_i};
    // R6 high pulse detected by rising edge
    assign line_rise = line_now & ~line_q;

    // R3 source selection
    always @* begin
        case (src)
            `CTC_SRC_ISO:    src_pulse = line_rise[0];
            `CTC_SRC_LINE_A: src_pulse = line_rise[1];
            `CTC_SRC_LINE_B: src_pulse = line_rise[2];
            default:         src_pulse = 1'b0;
        endcase
    end

    // R10 divider source is separate
    always @* begin
        case (csrc)
            `CTC_SRC_ISO:    cnt_pulse = line_rise[0];
            `CTC_SRC_LINE_A: cnt_pulse = line_rise[1];
            `CTC_SRC_LINE_B: cnt_pulse = line_rise[2];
            default:         cnt_pulse = 1'b0;
        endcase
    end

    // R9 divide by n; R4 R5 software command only with software source
    always @* begin
        if (acq == `CTC_ACQ_COUNTER) begin
            trig = cnt_pulse & (div_cnt + 10'h001 >= div_ratio);
        end else if (src == `CTC_SRC_SOFT) begin
            trig = soft_req;
        end else begin
            trig = src_pulse;
        end
    end

    // registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl       <= `CTC_CTRL_RESET;
            burst_cnt  <= `CTC_BURST_RESET;
            div_ratio  <= `CTC_DIV_RESET;
            expose_len <= `CTC_EXPOSE_RESET;
            soft_req   <= 1'b0;
            cnt_clr    <= 1'b0;
            stop_req   <= 1'b0;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
            line_q     <= 3'h0;
        end else begin
            line_q   <= line_now;
            wb_ack_o <= wb_req;
            soft_req <= 1'b0;
            cnt_clr  <= 1'b0;
            stop_req <= 1'b0;
            // R5 stop ends a cyclic run; a pulse alone would miss the frame end
            if (stop_req)
                ctrl[`CTC_CTRL_CYCLIC] <= 1'b0;
            if (wr) begin
                case (wb_adr_i)
                    `CTC_REG_CTRL: begin
                        if (wb_sel_i[0]) ctrl[7:0]  <= wb_dat_i[7:0];
                        if (wb_sel_i[1]) ctrl[11:8] <= wb_dat_i[11:8];
                    end
                    `CTC_REG_BURST: begin
                        // R8 count of zero kept at one
                        if (wb_sel_i[1:0] == 2'h3)
                            burst_cnt <= (wb_dat_i[15:0] == 16'h0000) ? 16'h0001 : wb_dat_i[15:0];
                    end
                    `CTC_REG_DIV: begin
                        if (wb_sel_i[1:0] == 2'h3)
                            div_ratio <= (wb_dat_i[9:0] == 10'h000) ? 10'h001 : wb_dat_i[9:0];
                    end
                    `CTC_REG_EXPOSE: begin
                        if (wb_sel_i[1:0] == 2'h3)
                            expose_len <= (wb_dat_i[15:0] == 16'h0000) ? 16'h0001 : wb_dat_i[15:0];
                    end
                    `CTC_REG_CMD: begin
                        if (wb_sel_i[0]) begin
                            soft_req <= wb_dat_i[`CTC_CMD_SOFT];
                            cnt_clr  <= wb_dat_i[`CTC_CMD_CNT_CLR];
                            stop_req <= wb_dat_i[`CTC_CMD_STOP];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            wb_dat_o <= 32'h0000_0000;
            if (wb_req & ~wb_we_i) begin
                case (wb_adr_i)
                    `CTC_REG_CTRL:   wb_dat_o <= {20'h00000, ctrl};
                    `CTC_REG_BURST:  wb_dat_o <= {16'h0000, burst_cnt};
                    `CTC_REG_DIV:    wb_dat_o <= {22'h000000, div_ratio};
                    `CTC_REG_EXPOSE: wb_dat_o <= {16'h0000, expose_len};
                    `CTC_REG_STATUS: wb_dat_o <= {frame_cnt, 2'h0, div_cnt, state};
                    `CTC_REG_LINES:  wb_dat_o <= {29'h00000000, line_now};
                    default:         wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // R11 divider count and clear
    always @(posedge clk_i) begin
        if (rst_i | cnt_clr | ~ctrl[`CTC_CTRL_TRIG_EN]) begin
            div_cnt <= 10'h000;
        end else if (acq == `CTC_ACQ_COUNTER && cnt_pulse && state == ST_WAIT) begin
            // R9 wrap at ratio
            div_cnt <= (div_cnt + 10'h001 >= div_ratio) ? 10'h000 : div_cnt + 10'h001;
        end
    end

    assign push      = (state == ST_SEND);
    assign push_data = {{(DATA_W-16){1'b0}}, frame_cnt[7:0], word_idx[7:0]};

    // acquisition sequence
    always @(posedge clk_i) begin
        if (rst_i) begin
            state       <= ST_IDLE;
            timer       <= 16'h0000;
            frames_left <= 16'h0000;
            word_idx    <= 16'h0000;
            frame_cnt   <= 16'h0000;
            exposing_o  <= 1'b0;
            last_flag   <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // R1 wait state entered directly
                    if (ctrl[`CTC_CTRL_TRIG_EN])
                        state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (~ctrl[`CTC_CTRL_TRIG_EN]) begin
                        state <= ST_IDLE;
                    end else if (trig) begin
                        // R2 exposure first; R7 single gives one frame; R8 burst count
                        state       <= ST_EXPO;
                        timer       <= expose_len;
                        exposing_o  <= 1'b1;
                        frames_left <= (acq == `CTC_ACQ_BURST) ? burst_cnt : 16'h0001;
                    end
                end
                ST_EXPO: begin
                    // R13 triggers ignored while busy
                    if (timer == 16'h0001) begin
                        exposing_o <= 1'b0;
                        word_idx   <= 16'h0000;
                        state      <= ST_SEND;
                    end else begin
                        timer <= timer - 16'h0001;
                    end
                end
                ST_SEND: begin
                    // R2 data only after exposure ends
                    if (push_ready) begin
                        if (word_idx == `CTC_FRAME_WORDS - 16'h0001) begin
                            frame_cnt <= frame_cnt + 16'h0001;
                            if (frames_left == 16'h0001) begin
                                // R5 cyclic repeat only for software source
                                if (ctrl[`CTC_CTRL_CYCLIC] && src == `CTC_SRC_SOFT &&
                                    acq != `CTC_ACQ_COUNTER && ~stop_req) begin
                                    state       <= ST_EXPO;
                                    timer       <= expose_len;
                                    exposing_o  <= 1'b1;
                                    frames_left <= (acq == `CTC_ACQ_BURST) ? burst_cnt : 16'h0001;
                                end else begin
                                    // R13 back to wait after last frame
                                    state <= ST_WAIT;
                                end
                            end else begin
                                frames_left <= frames_left - 16'h0001;
                                timer       <= expose_len;
                                exposing_o  <= 1'b1;
                                state       <= ST_EXPO;
                            end
                        end else begin
                            word_idx <= word_idx + 16'h0001;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // R7 last marker rides in the buffer with its word, so a stall cannot split them
    assign last_word    = (word_idx == `CTC_FRAME_WORDS - 16'h0001);
    assign frame_data_o = skid_out[DATA_W-1:0];

    // buffer memory has no reset, so the marker is qualified by valid
    always @* begin
        frame_last_o = frame_valid_o & skid_out[DATA_W];
    end

    // stall by receiver holds the sender, no word lost
    ctc_skid #(
        .WIDTH (DATA_W + 1)
    ) u_skid (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   ({last_word, push_data}),
        .in_valid_i  (push),
        .in_ready_o  (push_ready),
        .out_data_o  (skid_out),
        .out_valid_o (frame_valid_o),
        .out_ready_i (frame_ready_i)
    );
endmodule // ctc_trigger_ctrl

// ### hdl/ctc_map.vh
// register map, field positions, reset values and codes of the trigger control block
`ifndef CTC_MAP_VH
`define CTC_MAP_VH
`define CTC_REG_CTRL      8'h00
`define CTC_REG_BURST     8'h04
`define CTC_REG_DIV       8'h08
`define CTC_REG_CMD       8'h0C
`define CTC_REG_STATUS    8'h10
`define CTC_REG_EXPOSE    8'h14
`define CTC_REG_LINES     8'h18
// control fields
`define CTC_CTRL_TRIG_EN  0
`define CTC_CTRL_SRC_LO   1
`define CTC_CTRL_SRC_HI   2
`define CTC_CTRL_ACQ_LO   3
`define CTC_CTRL_ACQ_HI   4
`define CTC_CTRL_CSRC_LO  5
`define CTC_CTRL_CSRC_HI  6
`define CTC_CTRL_DIR_A    7
`define CTC_CTRL_DIR_B    8
`define CTC_CTRL_OUT_A    9
`define CTC_CTRL_OUT_B    10
`define CTC_CTRL_CYCLIC   11
`define CTC_CTRL_RESET    12'h000
// command bits (write one to act)
`define CTC_CMD_SOFT      0
`define CTC_CMD_CNT_CLR   1
`define CTC_CMD_STOP      2
// trigger sources
`define CTC_SRC_SOFT      2'h0
`define CTC_SRC_ISO       2'h1
`define CTC_SRC_LINE_A    2'h2
`define CTC_SRC_LINE_B    2'h3
// acquisition modes
`define CTC_ACQ_SINGLE    2'h0
`define CTC_ACQ_BURST     2'h1
`define CTC_ACQ_COUNTER   2'h2
// reset values and frame length in words
`define CTC_BURST_RESET   16'h0001
`define CTC_DIV_RESET     10'h001
`define CTC_EXPOSE_RESET  16'h0064
`define CTC_FRAME_WORDS   16'h0010
`endif

// ### hdl/ctc_skid.v
// two-entry buffer between the frame word source and the receiver
`timescale 1ns/100ps
module ctc_skid #(
    parameter WIDTH = 32
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:1];
    reg             wr_ptr;
    reg             rd_ptr;
    reg [1:0]       count;
    wire            push;
    wire            pop;

    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push & ~pop) begin
                count <= count + 2'h1;
            end else if (pop & ~push) begin
                count <= count - 2'h1;
            end
        end
    end

    // memory holds no control state, so it needs no reset
    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule // ctc_skid

// ### tb/ctc_far_model.sv
// far side model: trigger equipment and frame receiver
`timescale 1ns/100ps
module ctc_far_model (
    input  wire        clk_i,
    input  wire [31:0] frame_data_i,
    input  wire        frame_valid_i,
    input  wire        frame_last_i,
    output reg         frame_ready_o,
    output reg         isolated_o,
    input  wire        line_a_drv_i,
    input  wire        line_a_oe_i,
    output wire        line_a_o,
    input  wire        line_b_drv_i,
    input  wire        line_b_oe_i,
    output wire        line_b_o,
    output reg  [15:0] words_o,
    output reg  [15:0] idx_err_o
);
    reg       drv_a = 1'b0;
    reg       drv_b = 1'b0;
    reg [1:0] stall = 2'h0;
    initial begin
        frame_ready_o = 1'b0;
        isolated_o = 1'b0;
        words_o = 16'h0;
        idx_err_o = 16'h0;
    end
    // the driving party decides the wire level
    assign line_a_o = line_a_oe_i ? line_a_drv_i : drv_a;
    assign line_b_o = line_b_oe_i ? line_b_drv_i : drv_b;
    // stall one cycle in three to exercise the buffer
    always @(posedge clk_i) begin
        stall <= (stall == 2'h2) ? 2'h0 : stall + 2'h1;
        frame_ready_o <= (stall != 2'h1);
        if (frame_valid_i && frame_ready_o) begin
            words_o <= words_o + 16'h1;
            if (frame_data_i[7:0] !== {4'h0, words_o[3:0]} || frame_last_i !== (words_o[3:0] == 4'hF))
                idx_err_o <= idx_err_o + 16'h1;
        end
    end
    task pulse(input int which);
        @(posedge clk_i);
        isolated_o <= (which == 1);
        drv_a <= (which == 2);
        drv_b <= (which == 3);
        repeat (3) @(posedge clk_i);
        isolated_o <= 1'b0;
        drv_a <= 1'b0;
        drv_b <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
endmodule // ctc_far_model

// ### tb/ctc_trigger_ctrl_chk.sv
// assertion checker for the trigger control block
`timescale 1ns/100ps
module ctc_trigger_chk (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        nonisolated_line_a_o,
    input wire        nonisolated_line_a_oe_o,
    input wire        nonisolated_line_b_o,
    input wire        nonisolated_line_b_oe_o,
    input wire        exposing_o,
    input wire [31:0] frame_data_o,
    input wire        frame_valid_o,
    input wire        frame_ready_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_dat_write; wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0; endproperty
    a_dat_write: assert property (p_dat_write) else $error("read data on a write");
    // a stalled word must not move or vanish
    property p_stall_hold; frame_valid_o && !frame_ready_i |=> frame_valid_o && $stable(frame_data_o); endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("stalled word lost");
    property p_expo_min; $rose(exposing_o) |-> exposing_o [*8]; endproperty
    a_expo_min: assert property (p_expo_min) else $error("exposure too short");
    property p_gap_min; $fell(exposing_o) |-> !exposing_o [*8]; endproperty
    a_gap_min: assert property (p_gap_min) else $error("new exposure before frame sent");
    property p_line_write;
        $changed({nonisolated_line_a_oe_o, nonisolated_line_b_oe_o, nonisolated_line_a_o, nonisolated_line_b_o})
            |-> wb_ack_o && wb_we_i;
    endproperty
    a_line_write: assert property (p_line_write) else $error("line setup changed without write");
endmodule // ctc_trigger_chk

bind ctc_trigger_ctrl ctc_trigger_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .nonisolated_line_a_o(nonisolated_line_a_o), .nonisolated_line_a_oe_o(nonisolated_line_a_oe_o),
    .nonisolated_line_b_o(nonisolated_line_b_o), .nonisolated_line_b_oe_o(nonisolated_line_b_oe_o),
    .exposing_o(exposing_o), .frame_data_o(frame_data_o[31:0]), .frame_valid_o(frame_valid_o),
    .frame_ready_i(frame_ready_i));

// ### tb/camera_trigger_control_tb_top.sv
// self-checking bench for the trigger control block
`timescale 1ns/100ps
`include "ctc_map.vh"
module camera_trigger_control_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] rd;
    logic [15:0] base;
    wire  [31:0] wb_rdat, frame_data;
    wire  [15:0] words, idx_err;
    wire         wb_ack, iso, la_i, la_o, la_oe, lb_i, lb_o, lb_oe, exposing, frame_valid, frame_ready, frame_last;
    int          n_fail = 0;
    int          comparisons = 0;

    always #50 clk_i = ~clk_i;

    ctc_trigger_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .isolated_in_i(iso), .nonisolated_line_a_i(la_i), .nonisolated_line_a_o(la_o), .nonisolated_line_a_oe_o(la_oe),
        .nonisolated_line_b_i(lb_i), .nonisolated_line_b_o(lb_o), .nonisolated_line_b_oe_o(lb_oe),
        .exposing_o(exposing), .frame_data_o(frame_data), .frame_valid_o(frame_valid), .frame_ready_i(frame_ready),
        .frame_last_o(frame_last));
    ctc_far_model i_far (.clk_i(clk_i), .frame_data_i(frame_data), .frame_valid_i(frame_valid), .frame_last_i(frame_last),
        .frame_ready_o(frame_ready), .isolated_o(iso), .line_a_drv_i(la_o), .line_a_oe_i(la_oe), .line_a_o(la_i),
        .line_b_drv_i(lb_o), .line_b_oe_i(lb_oe), .line_b_o(lb_i), .words_o(words), .idx_err_o(idx_err));

    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // classic single cycle; waits for ack without assuming its latency
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= w;
        wb_adr  <= a;
        wb_wdat <= d;
        wb_sel  <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        if (n >= 50) n_fail++;
    endtask
    task idle;
        int n;
        repeat (6) @(posedge clk_i);
        n = 0;
        do begin
            wb(`CTC_REG_STATUS, 1'b0, 32'h0, 4'hF);
            n++;
        end while (rd[3:0] !== 4'h2 && n < 100);
        chk(rd[3:0], 4'h2, "back to waiting");
        repeat (8) @(posedge clk_i);
    endtask
    task settle(input int nf, input string msg);
        idle;
        chk({16'h0, words - base}, nf * `CTC_FRAME_WORDS, msg);
        base = words;
    endtask
    task mode(input logic [1:0] src, input logic [1:0] acq);
        wb(`CTC_REG_CTRL, 1'b1, {25'h0, `CTC_SRC_LINE_B, acq, src, 1'b1}, 4'hF);
    endtask
    task t_regs;
        logic [7:0]  a [5] = '{`CTC_REG_CTRL, `CTC_REG_BURST, `CTC_REG_DIV, `CTC_REG_EXPOSE, 8'h40};
        logic [31:0] e [5] = '{32'h0, 32'h1, 32'h1, 32'h64, 32'h0};
        for (int i = 0; i < 5; i++) begin
            wb(a[i], 1'b0, 32'h0, 4'hF);
            chk(rd, e[i], "register reset value");
        end
        wb(`CTC_REG_EXPOSE, 1'b1, 32'h8, 4'h1);
        wb(`CTC_REG_EXPOSE, 1'b0, 32'h0, 4'hF);
        chk(rd, 32'h64, "partial write ignored");
        wb(`CTC_REG_EXPOSE, 1'b1, 32'h8, 4'hF);
        wb(`CTC_REG_EXPOSE, 1'b0, 32'h0, 4'hF);
        chk(rd, 32'h8, "exposure written");
    endtask
    task t_lines;
        wb(`CTC_REG_CTRL, 1'b1, 32'h280, 4'hF);
        chk({la_oe, la_o, lb_oe, lb_o, la_i}, 5'h19, "line a output");
        wb(`CTC_REG_CTRL, 1'b1, 32'h500, 4'hF);
        chk({la_oe, la_o, lb_oe, lb_o, lb_i}, 5'h07, "line b output");
    endtask
    task t_soft;
        int n;
        logic v;
        mode(`CTC_SRC_SOFT, `CTC_ACQ_SINGLE);
        wb(`CTC_REG_STATUS, 1'b0, 32'h0, 4'hF);
        chk(rd[3:0], 4'h2, "waiting after enable");
        wb(`CTC_REG_CMD, 1'b1, 32'h1, 4'hF);
        for (n = 0; exposing !== 1'b1 && n < 20; n++) @(posedge clk_i);
        v = 1'b0;
        for (n = 0; exposing === 1'b1 && n < 200; n++) begin
            v |= frame_valid;
            @(posedge clk_i);
        end
        chk(n, 32'h8, "exposure length");
        chk(v, 1'b0, "data during exposure");
        settle(1, "single soft frame");
    endtask
    task t_hw;
        for (int s = 1; s < 4; s++) begin
            mode(s[1:0], `CTC_ACQ_SINGLE);
            i_far.pulse(s);
            settle(1, "hardware source frame");
        end
        wb(`CTC_REG_CMD, 1'b1, 32'h1, 4'hF);
        settle(0, "soft command on line source");
    endtask
    task t_burst;
        for (int b = 1; b < 4; b += 2) begin
            wb(`CTC_REG_BURST, 1'b1, b, 4'hF);
            mode(`CTC_SRC_ISO, `CTC_ACQ_BURST);
            i_far.pulse(1);
            repeat (10) @(posedge clk_i);
            i_far.pulse(1);
            settle(b, "burst frame count");
        end
    endtask
    task t_counter;
        wb(`CTC_REG_DIV, 1'b1, 32'h3, 4'hF);
        mode(`CTC_SRC_ISO, `CTC_ACQ_COUNTER);
        repeat (2) i_far.pulse(3);
        wb(`CTC_REG_CMD, 1'b1, 32'h2, 4'hF);
        repeat (2) i_far.pulse(3);
        i_far.pulse(1);
        settle(0, "count cleared and other line ignored");
        i_far.pulse(3);
        settle(1, "third edge triggers");
        chk({16'h0, idx_err}, 32'h0, "word order in frames");
    endtask
    task t_cyclic;
        int n;
        wb(`CTC_REG_CTRL, 1'b1, 32'h803, 4'hF);
        i_far.pulse(1);
        settle(1, "cyclic ignored on line source");
        wb(`CTC_REG_CTRL, 1'b1, 32'h801, 4'hF);
        wb(`CTC_REG_CMD, 1'b1, 32'h1, 4'hF);
        for (n = 0; words - base < 16'h0030 && n < 400; n++) @(posedge clk_i);
        chk(n < 400, 1'b1, "cyclic soft repeats");
        wb(`CTC_REG_CMD, 1'b1, 32'h4, 4'hF);
        idle;
        chk({28'h0, words[3:0] - base[3:0]}, 32'h0, "cyclic stops on a frame end");
        base = words;
        chk({16'h0, idx_err}, 32'h0, "word order and last marker");
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({la_oe, lb_oe, la_o, lb_o, exposing, frame_valid, frame_last, wb_ack}, 8'h00, "outputs after reset");
        base = words;
        t_regs;
        t_lines;
        t_soft;
        t_hw;
        t_burst;
        t_counter;
        t_cyclic;
        close_out;
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        close_out;
    end
endmodule // camera_trigger_control_tb_top
